// >>> core/dcps_serial_port.sv
// Purpose: Dual-channel PCM serial port, internal or external framing.
// Assumes: clk_i stands in for the oscillator input; pins are asynchronous.
// Notes:   Pin inputs other than ext_clk_mode_i pass dcps_sync2 before any logic looks at them.
// Behaviour
// - System clock out is core clock over four
// - Receive line 1 channel 1, line 2 channel 2
// - Transmit lines per channel, high-Z when idle
// - Internal mode: 8 kHz sync pulse starts both
// - External receive frame: fall starts, rise delivers
// - External transmit frame: fall starts, rise loads
// - Bit clock input external, driven output internal
// - Reset floats bit clock and transmit lines
// - Receive bits sampled on bit clock fall
// - Frame inputs sampled on bit clock fall
// - Reset floats the coprocessor data bus
// - Samples shift most significant bit first
`timescale 1ns/1ps
module dcps_serial_port #(
  parameter int unsigned SCLK_HALF  = dcps_pkg::SCLK_HALF_CYC,
  parameter int unsigned FRAME_BITS = dcps_pkg::FRAME_BITS
) (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ext_clk_mode_i,
  input  wire logic                          sclk_i,
  output logic                               sclk_o,
  output logic                               sclk_oe_o,
  input  wire logic                          rx_sync_in_i,
  input  wire logic                          tx_sync_in_i,
  output logic                               internal_sync_pulse_o,
  input  wire logic                          rx_line_ch1_i,
  input  wire logic                          rx_line_ch2_i,
  output logic                               tx_line_ch1_o,
  output logic                               tx_line_ch1_oe_o,
  output logic                               tx_line_ch2_o,
  output logic                               tx_line_ch2_oe_o,
  input  wire logic [dcps_pkg::SAMPLE_W-1:0] tx_sample_ch1_i,
  input  wire logic [dcps_pkg::SAMPLE_W-1:0] tx_sample_ch2_i,
  output logic                               tx_load_o,
  output logic [dcps_pkg::SAMPLE_W-1:0]      rx_sample_ch1_o,
  output logic [dcps_pkg::SAMPLE_W-1:0]      rx_sample_ch2_o,
  output logic                               rx_valid_o,
  output logic                               sys_clk_out_o,
  output logic [dcps_pkg::SAMPLE_W-1:0]      data_bus_o,
  output logic                               data_bus_oe_o
);
  import dcps_pkg::*;

  logic                 sclk_s;        // Bit clock, second stage
  logic                 sclk_d_reg;    // Bit clock, one cycle older
  logic [CH_NUM-1:0]    rx_line_s;     // Receive lines, channel order
  logic                 rx_fs_s;       // Receive frame, active low
  logic                 tx_fs_s;       // Transmit frame, active low

  // Bit clock and data share one delay so they stay aligned
  dcps_sync2 #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync_sclk (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .d_i     (sclk_i),
    .q_o     (sclk_s)
  );

  // Line 1 feeds channel 1, line 2 channel 2
  dcps_sync2 #(
    .W       (CH_NUM),
    .RST_VAL (LINE_RST)
  ) u_sync_rx (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .d_i     ({rx_line_ch2_i, rx_line_ch1_i}),
    .q_o     (rx_line_s)
  );

  // Frame inputs reset to idle high, avoiding a false start
  dcps_sync2 #(
    .W       (2),
    .RST_VAL ({FS_IDLE, FS_IDLE})
  ) u_sync_fs (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .d_i     ({tx_sync_in_i, rx_sync_in_i}),
    .q_o     ({tx_fs_s, rx_fs_s})
  );
  logic sys_div_reg;   // Half-rate phase
  logic sys_clk_reg;   // Quarter-rate output

  // Toggle every second cycle: clk divided by four
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_div_reg <= 1'b0;
      sys_clk_reg <= 1'b0;
    end else begin
      sys_div_reg <= ~sys_div_reg;
      if (sys_div_reg) begin
        sys_clk_reg <= ~sys_clk_reg;
      end
    end
  end
  assign sys_clk_out_o = sys_clk_reg;
  wire int_mode = ~ext_clk_mode_i;   // Static config, same clock domain

  logic [SCLK_DIV_W-1:0]  div_cnt_reg;   // Half-period counter
  logic                   sclk_reg;      // Driven bit clock level
  logic                   sclk_oe_reg;   // Bit clock pin drive
  logic [FRAME_CNT_W-1:0] bit_cnt_reg;   // Bit slot in frame
  logic                   pulse_reg;     // Internal sync pulse

  wire div_hit  = (div_cnt_reg == SCLK_DIV_W'(SCLK_HALF - 1));
  wire int_rise = int_mode & div_hit & ~sclk_reg;
  wire int_fall = int_mode & div_hit &  sclk_reg;
  wire [FRAME_CNT_W-1:0] bit_cnt_next =
    (bit_cnt_reg == FRAME_CNT_W'(FRAME_BITS - 1)) ? FRAME_RST
                                                   : bit_cnt_reg + 1'b1;

  // Generate the 2.048 MHz clock only in internal mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_reg <= DIV_RST;
      sclk_reg    <= 1'b0;
      sclk_oe_reg <= 1'b0;
    end else begin
      // Pin is an output only with internal clocking
      sclk_oe_reg <= int_mode;
      if (!int_mode) begin
        // Divider parked so the first internal edge is clean
        div_cnt_reg <= DIV_RST;
        sclk_reg    <= 1'b0;
      end else if (div_hit) begin
        div_cnt_reg <= DIV_RST;
        sclk_reg    <= ~sclk_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end
  // Reset clears the drive, floating the pin
  assign sclk_o    = sclk_reg;
  assign sclk_oe_o = sclk_oe_reg;

  // Pulse high for the last slot, one bit period
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_reg <= FRAME_RST;
      pulse_reg   <= 1'b0;
    end else if (!int_mode) begin
      bit_cnt_reg <= FRAME_RST;
      pulse_reg   <= 1'b0;
    end else if (int_rise) begin
      bit_cnt_reg <= bit_cnt_next;
      pulse_reg   <= (bit_cnt_next == FRAME_CNT_W'(FRAME_BITS - 1));
    end
  end
  assign internal_sync_pulse_o = pulse_reg;
  // External edges from the synchronised pin, older copy vs newer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end
  wire ext_rise  = ~sclk_d_reg &  sclk_s;
  wire ext_fall  =  sclk_d_reg & ~sclk_s;
  wire sclk_rise = int_mode ? int_rise : ext_rise;
  wire sclk_fall = int_mode ? int_fall : ext_fall;
  logic rx_fs_smp_reg;   // Receive frame at last fall
  logic tx_fs_smp_reg;   // Transmit frame at last fall

  // Frame levels are taken only at bit clock falls
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_fs_smp_reg <= FS_IDLE;
      tx_fs_smp_reg <= FS_IDLE;
    end else if (sclk_fall) begin
      rx_fs_smp_reg <= rx_fs_s;
      tx_fs_smp_reg <= tx_fs_s;
    end
  end

  // Receive frame fall starts, rise releases the word
  wire rx_fs_fall = sclk_fall & ~int_mode &  rx_fs_smp_reg & ~rx_fs_s;
  wire rx_fs_rise = sclk_fall & ~int_mode & ~rx_fs_smp_reg &  rx_fs_s;
  // Transmit frame fall starts, rise loads next word
  wire tx_fs_fall = sclk_fall & ~int_mode &  tx_fs_smp_reg & ~tx_fs_s;
  wire tx_fs_rise = sclk_fall & ~int_mode & ~tx_fs_smp_reg &  tx_fs_s;

  // Both directions start on the same internal pulse
  wire rx_start = int_mode ? (sclk_fall & pulse_reg) : rx_fs_fall;
  wire tx_start = int_mode ? (sclk_fall & pulse_reg) : tx_fs_fall;
  wire tx_load  = int_mode ? tx_start : tx_fs_rise;
  logic [BIT_LEFT_W-1:0] rx_left_reg;   // Bits still to sample
  logic                  rx_done_reg;   // Word waiting for release
  logic                  rx_valid_reg;  // Delivery strobe

  wire rx_take    = sclk_fall & ~rx_start & (rx_left_reg != LEFT_RST);
  wire rx_last    = rx_take & (rx_left_reg == BIT_LEFT_W'(1));
  // Internal mode releases at once, external waits for frame rise
  wire rx_deliver = rx_done_reg & (int_mode | rx_fs_rise);

  // Eight falls after the start carry the sample
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_left_reg  <= LEFT_RST;
      rx_done_reg  <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_deliver;
      if (rx_start) begin
        rx_left_reg <= BIT_LEFT_W'(SAMPLE_W);
      end else if (rx_take) begin
        rx_left_reg <= rx_left_reg - 1'b1;
      end
      // A finishing word wins over a release in the same cycle
      if (rx_last) begin
        rx_done_reg <= 1'b1;
      end else if (rx_deliver || rx_start) begin
        rx_done_reg <= 1'b0;
      end
    end
  end
  assign rx_valid_o = rx_valid_reg;
  dcps_tx_state_t        tx_state_reg;   // Shifter state
  logic [BIT_LEFT_W-1:0] tx_left_reg;    // Bits still to drive
  logic                  tx_oe_reg;      // Shared line drive
  logic                  tx_load_reg;    // Load strobe out

  wire tx_drive = sclk_rise & (tx_left_reg != LEFT_RST);

  // Drive eight bits on the rises after the start
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_state_reg <= DCPS_TX_IDLE;
      tx_left_reg  <= LEFT_RST;
      tx_oe_reg    <= 1'b0;
      tx_load_reg  <= 1'b0;
    end else begin
      tx_load_reg <= tx_load;
      case (tx_state_reg)
        DCPS_TX_IDLE: begin
          if (tx_start) begin
            tx_left_reg  <= BIT_LEFT_W'(SAMPLE_W);
            tx_state_reg <= DCPS_TX_SHIFT;
          end
        end
        DCPS_TX_SHIFT: begin
          if (tx_start) begin
            // New frame restarts the count
            tx_left_reg <= BIT_LEFT_W'(SAMPLE_W);
          end else if (tx_drive) begin
            tx_oe_reg   <= 1'b1;
            tx_left_reg <= tx_left_reg - 1'b1;
          end else if (sclk_rise) begin
            // Last bit held until the next rise, then float
            tx_oe_reg    <= 1'b0;
            tx_state_reg <= DCPS_TX_IDLE;
          end
        end
        default: begin
          tx_state_reg <= DCPS_TX_IDLE;
          tx_oe_reg    <= 1'b0;
        end
      endcase
    end
  end
  assign tx_load_o = tx_load_reg;
  logic [SAMPLE_W-1:0] tx_in_w   [CH_NUM];   // Sample inputs
  logic [SAMPLE_W-1:0] rx_word_reg [CH_NUM]; // Delivered samples
  logic                tx_bit_reg [CH_NUM];  // Line data bits, one owner each

  assign tx_in_w[0] = tx_sample_ch1_i;
  assign tx_in_w[1] = tx_sample_ch2_i;

  // Both channels share timing; only data differs
  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch
    logic [SAMPLE_W-1:0] rx_shift_reg;   // Incoming bits
    logic [SAMPLE_W-1:0] tx_shift_reg;   // Outgoing bits
    logic [SAMPLE_W-1:0] tx_hold_reg;    // Word for next frame

    // Sample on the fall, shifting MSB first
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        rx_shift_reg    <= SAMPLE_RST;
        rx_word_reg[ch] <= SAMPLE_RST;
      end else begin
        // Earliest bit ends up as the MSB
        if (rx_take) begin
          rx_shift_reg <= {rx_shift_reg[SAMPLE_W-2:0], rx_line_s[ch]};
        end
        if (rx_deliver) begin
          rx_word_reg[ch] <= rx_shift_reg;
        end
      end
    end

    // Send MSB first; hold buffers one frame ahead
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        tx_shift_reg   <= SAMPLE_RST;
        tx_hold_reg    <= SAMPLE_RST;
        tx_bit_reg[ch] <= 1'b0;
      end else begin
        if (tx_start) begin
          tx_shift_reg <= tx_hold_reg;
        end else if (tx_drive) begin
          tx_bit_reg[ch] <= tx_shift_reg[SAMPLE_W-1];
          tx_shift_reg   <= {tx_shift_reg[SAMPLE_W-2:0], 1'b0};
        end
        if (tx_load) begin
          tx_hold_reg <= tx_in_w[ch];
        end
      end
    end
  end

  assign rx_sample_ch1_o = rx_word_reg[0];
  assign rx_sample_ch2_o = rx_word_reg[1];

  // Lines float whenever no bit is being driven
  assign tx_line_ch1_o    = tx_bit_reg[0];
  assign tx_line_ch2_o    = tx_bit_reg[1];
  assign tx_line_ch1_oe_o = tx_oe_reg;
  assign tx_line_ch2_oe_o = tx_oe_reg;
  logic [SAMPLE_W-1:0] bus_data_reg;   // Bus data, unused here
  logic                bus_oe_reg;     // Bus drive

  // Host port is outside this block; bus stays released
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_data_reg <= SAMPLE_RST;
      bus_oe_reg   <= 1'b0;
    end else begin
      bus_data_reg <= SAMPLE_RST;
      bus_oe_reg   <= 1'b0;
    end
  end
  assign data_bus_o    = bus_data_reg;
  assign data_bus_oe_o = bus_oe_reg;

endmodule

// >>> core/dcps_pkg.sv
// Purpose: Shared constants for the dual-channel PCM serial port.
// Assumes: Core clock clk_i at 25 MHz (40 ns period).
// Notes:   Times are kept in ns, except the reset pulse in cycles; SCLK_HALF_CYC is derived from them.
package dcps_pkg;

  // Core clock period
  localparam int unsigned CLK_PERIOD_NS  = 40;

  // Number of PCM channels
  localparam int unsigned CH_NUM         = 2;

  // Bits per PCM sample (one A-law byte per channel per frame)
  localparam int unsigned SAMPLE_W       = 8;

  // Bit-count width, enough to hold SAMPLE_W
  localparam int unsigned BIT_LEFT_W     = 4;

  // Bits per frame: 2.048 MHz bit clock over 8 kHz frame
  localparam int unsigned BIT_RATE_KHZ   = 2048;
  localparam int unsigned FRAME_RATE_KHZ = 8;
  localparam int unsigned FRAME_BITS     = BIT_RATE_KHZ / FRAME_RATE_KHZ;
  localparam int unsigned FRAME_CNT_W    = 8;

  // Half period of the internally made bit clock
  localparam int unsigned SCLK_HALF_NS   = 244;
  // Rounded down, never below one cycle
  localparam int unsigned SCLK_HALF_CYC  =
    (SCLK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCLK_HALF_NS / CLK_PERIOD_NS);
  localparam int unsigned SCLK_DIV_W     = 8;

  // Least frame setup before the sampling bit clock edge
  localparam int unsigned FS_SETUP_NS    = 100;
  // Least reset pulse in core clock cycles
  localparam int unsigned RESET_MIN_CYC  = 5;

  // Reset values
  localparam logic [SAMPLE_W-1:0]   SAMPLE_RST = 8'h00;
  localparam logic [CH_NUM-1:0]     LINE_RST   = 2'h0;
  localparam logic [BIT_LEFT_W-1:0] LEFT_RST   = 4'h0;
  localparam logic [FRAME_CNT_W-1:0] FRAME_RST = 8'h00;
  localparam logic [SCLK_DIV_W-1:0] DIV_RST    = 8'h00;
  // Frame inputs idle high, so their sampled copies reset high
  localparam logic                  FS_IDLE    = 1'b1;

  // Transmit shifter states
  typedef enum logic [1:0] {
    DCPS_TX_IDLE  = 2'b01,
    DCPS_TX_SHIFT = 2'b10
  } dcps_tx_state_t;

endpackage

// >>> core/dcps_sync2.sv
// Purpose: Two-flop synchroniser for levels entering from outside.
// Assumes: Inputs are slow levels relative to clk_i.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module dcps_sync2 #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // Metastability catch stage
  logic [W-1:0] meta_reg;

  // Both stages clear to the idle value of the pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// >>> verification/dcps_port_monitor.sv
// Purpose: Pin-level checks for the PCM serial port.
// Assumes: Mode input moves only while reset is held.
// Notes:   Windows follow the designer's stated latencies.
`timescale 1ns/1ps
module dcps_port_monitor #(
  parameter int unsigned SCLK_HALF  = 6,
  parameter int unsigned FRAME_BITS = 256
) (
  input wire logic                          clk_i,
  input wire logic                          rstn_i,
  input wire logic                          ext_clk_mode_i,
  input wire logic                          sclk_o,
  input wire logic                          sclk_oe_o,
  input wire logic                          internal_sync_pulse_o,
  input wire logic                          tx_line_ch1_oe_o,
  input wire logic                          tx_line_ch2_oe_o,
  input wire logic [dcps_pkg::SAMPLE_W-1:0] rx_sample_ch1_o,
  input wire logic                          rx_valid_o,
  input wire logic                          sys_clk_out_o,
  input wire logic                          data_bus_oe_o
);
  import dcps_pkg::*;
  logic [7:0]  half_reg; // Cycles the bit clock has stood
  logic [15:0] frm_reg;  // Cycles since the last frame pulse
  logic [7:0]  oe_reg;   // Cycles the lines have been driven
  logic        hseen_reg; // First count is partial, so skip it
  logic        fseen_reg; // Same for the frame count
  // Bit clock, frame and line drive counters
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_reg  <= 8'h00;
      hseen_reg <= 1'b0;
    end else begin
      half_reg  <= $changed(sclk_o) ? 8'h01 : half_reg + 8'h01;
      hseen_reg <= hseen_reg | $changed(sclk_o);
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frm_reg   <= 16'h0000;
      fseen_reg <= 1'b0;
      oe_reg    <= 8'h00;
    end else begin
      frm_reg   <= $rose(internal_sync_pulse_o) ? 16'h0001 : frm_reg + 16'h0001;
      fseen_reg <= fseen_reg | $rose(internal_sync_pulse_o);
      oe_reg    <= tx_line_ch1_oe_o ? oe_reg + 8'h01 : 8'h00;
    end
  end
  default clocking dflt_cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Two cycles high, two low
  sequence div_step_s;
    sys_clk_out_o ##1 !sys_clk_out_o [*2] ##1 sys_clk_out_o;
  endsequence
  // Both lines come up together about one bit later
  sequence lines_up_s;
    ##[8:16] ($rose(tx_line_ch1_oe_o) && tx_line_ch2_oe_o);
  endsequence
  chk_div_quarter:
    assert property ($rose(sys_clk_out_o) |=> div_step_s) else $error("bad clock divide");
  chk_reset_float:
    assert property (disable iff (1'b0) !rstn_i |-> !(sclk_oe_o || tx_line_ch1_oe_o
      || tx_line_ch2_oe_o || data_bus_oe_o)) else $error("pin driven in reset");
  chk_ext_quiet:
    assert property (ext_clk_mode_i |-> !sclk_oe_o && !internal_sync_pulse_o)
    else $error("drive in external mode");
  chk_int_drive:
    assert property (!ext_clk_mode_i ##1 !ext_clk_mode_i |=> sclk_oe_o)
    else $error("bit clock not driven");
  chk_bit_half:
    assert property (!ext_clk_mode_i && hseen_reg && $changed(sclk_o) |-> half_reg == SCLK_HALF)
    else $error("bad bit clock half period");
  chk_frame_rate:
    assert property ($rose(internal_sync_pulse_o) && fseen_reg
      |-> frm_reg == 2 * SCLK_HALF * FRAME_BITS) else $error("bad frame period");
  chk_both_start:
    assert property ($rose(internal_sync_pulse_o) |-> lines_up_s) else $error("no shift start");
  chk_word_len:
    assert property ($fell(tx_line_ch1_oe_o) && !ext_clk_mode_i |-> oe_reg == 16 * SCLK_HALF)
    else $error("word not eight bits");
  chk_rx_deliver:
    assert property ($changed(rx_sample_ch1_o) |-> rx_valid_o) else $error("sample without valid");
endmodule
bind dcps_serial_port dcps_port_monitor #(
  .SCLK_HALF  (SCLK_HALF),
  .FRAME_BITS (FRAME_BITS)
) u_dcps_port_monitor (
  .clk_i                 (clk_i),
  .rstn_i                (rstn_i),
  .ext_clk_mode_i        (ext_clk_mode_i),
  .sclk_o                (sclk_o),
  .sclk_oe_o             (sclk_oe_o),
  .internal_sync_pulse_o (internal_sync_pulse_o),
  .tx_line_ch1_oe_o      (tx_line_ch1_oe_o),
  .tx_line_ch2_oe_o      (tx_line_ch2_oe_o),
  .rx_sample_ch1_o       (rx_sample_ch1_o),
  .rx_valid_o            (rx_valid_o),
  .sys_clk_out_o         (sys_clk_out_o),
  .data_bus_oe_o         (data_bus_oe_o)
);

// >>> verification/dcps_codec_model.sv
// Purpose: Codec side of the link; makes bit clock and frames when external.
// Assumes: One frame per change of go_i; mode is steady meanwhile.
// Notes:   Bit clock stands low between frames; idle data is inverted.
`timescale 1ns/1ps
module dcps_codec_model (
  input  wire logic       ext_i,
  input  wire logic       go_i,
  input  wire logic       cut_i,
  input  wire logic       bclk_i,
  input  wire logic       pulse_i,
  input  wire logic       txw1_i,
  input  wire logic       txw2_i,
  input  wire logic [7:0] rxw1_i,
  input  wire logic [7:0] rxw2_i,
  output logic            sclk_o,
  output logic            sync_n_o,
  output logic            rxd1_o,
  output logic            rxd2_o,
  output logic [7:0]      txw1_o,
  output logic [7:0]      txw2_o,
  output logic            done_o
);
  int j; // Bit slot in the frame
  // One frame per request
  initial begin
    sclk_o   = 1'b0;
    sync_n_o = 1'b1;
    rxd1_o   = 1'b0;
    rxd2_o   = 1'b1;
    done_o   = 1'b0;
    #100;
    forever begin
      @(go_i);
      if (ext_i) #13;
      else @(posedge pulse_i);
      for (j = 0; j < 11; j++) begin
        // bit clock 320 ns, even duty
        if (ext_i) #160;
        else if (j > 0) @(negedge bclk_i);
        // tx bits taken mid-bit, MSB first
        if (j > 1 && j < 10) begin
          txw1_o = {txw1_o[6:0], txw1_i};
          txw2_o = {txw2_o[6:0], txw2_i};
        end
        // Internal bits change on the rise itself, so never sample there
        if (!ext_i && j > 0) @(posedge bclk_i);
        sclk_o = ext_i;
        // frame low from first to tenth rise, or to sixth rise when cut_i is set
        if (j == 0) sync_n_o = 1'b0;
        if (j == (cut_i ? 5 : 9)) sync_n_o = 1'b1;
        // data set at rise, taken at fall
        rxd1_o = (j > 0 && j < 9) ? rxw1_i[8-j] : ~rxd1_o;
        rxd2_o = (j > 0 && j < 9) ? rxw2_i[8-j] : ~rxd2_o;
        if (ext_i) #160 sclk_o = 1'b0;
      end
      #400 done_o = ~done_o;
    end
  end
endmodule

// >>> verification/dcps_serial_port_bench.sv
// Purpose: Self-checking bench for the dual-channel PCM serial port.
// Assumes: Mode changes only while reset is held.
// Notes:   Frames cut to 16 bits to keep the run short.
`timescale 1ns/1ps
module dcps_serial_port_bench;
  import dcps_pkg::*;
  logic clk_i, rstn_i, ext, go, cut, done, dseen, m_sclk, sync_n, rxd1, rxd2;
  logic sclk, sclk_oe, pulse, tx1, tx1_oe, tx2, tx2_oe, load, rvalid, sysclk, bus_oe;
  logic [7:0] smp1, smp2, rs1, rs2, rw1, rw2, mtx1, mtx2, bus_d;
  wire bclk = sclk_oe ? sclk : m_sclk; // Shared bit clock pin
  wire txw1 = tx1_oe ? tx1 : 1'bz;     // Released line floats
  wire txw2 = tx2_oe ? tx2 : 1'bz;
  int err_total, total_checks, vcnt, lcnt;
  dcps_serial_port #(.FRAME_BITS(16)) u_dcps_serial_port (
    .clk_i(clk_i), .rstn_i(rstn_i), .ext_clk_mode_i(ext), .sclk_i(bclk),
    .sclk_o(sclk), .sclk_oe_o(sclk_oe), .rx_sync_in_i(sync_n), .tx_sync_in_i(sync_n),
    .internal_sync_pulse_o(pulse), .rx_line_ch1_i(rxd1), .rx_line_ch2_i(rxd2),
    .tx_line_ch1_o(tx1), .tx_line_ch1_oe_o(tx1_oe), .tx_line_ch2_o(tx2),
    .tx_line_ch2_oe_o(tx2_oe), .tx_sample_ch1_i(smp1), .tx_sample_ch2_i(smp2),
    .tx_load_o(load), .rx_sample_ch1_o(rs1), .rx_sample_ch2_o(rs2), .rx_valid_o(rvalid),
    .sys_clk_out_o(sysclk), .data_bus_o(bus_d), .data_bus_oe_o(bus_oe));
  dcps_codec_model u_dcps_codec_model (
    .ext_i(ext), .go_i(go), .cut_i(cut), .bclk_i(bclk), .pulse_i(pulse),
    .txw1_i(txw1), .txw2_i(txw2), .rxw1_i(rw1), .rxw2_i(rw2), .sclk_o(m_sclk),
    .sync_n_o(sync_n), .rxd1_o(rxd1), .rxd2_o(rxd2), .txw1_o(mtx1), .txw2_o(mtx2),
    .done_o(done));
  always #20 clk_i = ~clk_i;
  // Count delivery and load pulses
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) vcnt++;
    if (load === 1'b1) lcnt++;
  end
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Reset with a mode, pins must float meanwhile
  task automatic reset_dut(input logic m);
    rstn_i = 1'b0;
    ext = m;
    // reset held well past five cycles
    repeat (12) @(negedge clk_i);
    check({sclk_oe, tx1_oe, tx2_oe, bus_oe}, 8'h00);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(sclk_oe, !m);
    check(bus_d, 8'h00);
  endtask
  // One frame from the codec model, bounded wait
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic c);
    int n;
    rw1 = a;
    rw2 = b;
    cut = c;
    go = ~go;
    n = 0;
    while (done === dseen) begin
      @(negedge clk_i);
      n++;
      if (n > 1500) begin
        err_total++;
        $display("mismatch at %0t: frame never ended", $time);
        complete_run();
      end
    end
    dseen = done;
  endtask
  // Load in one frame, send in the next; receive both ways
  task automatic xfer(input logic [7:0] a, input logic [7:0] b);
    int v, l;
    smp1 = ~a;
    smp2 = {a[3:0], b[7:4]};
    frame(a, b, 1'b0);
    v = vcnt;
    l = lcnt;
    frame(b, a, 1'b0);
    check(rs1, b);
    check(rs2, a);
    check(mtx1, ~a);
    check(mtx2, {a[3:0], b[7:4]});
    if (ext) check(8'(vcnt - v), 8'h01);
    if (ext) check(8'(lcnt - l), 8'h01);
  endtask
  // Frame ends after four bits: nothing delivered
  task automatic short_frame();
    int v;
    v = vcnt;
    frame(8'hF0, 8'h0F, 1'b1);
    check(8'(vcnt - v), 8'h00);
    check(rs1, 8'h6B);
  endtask
  // Reset while shifting floats the lines at once
  task automatic reset_mid();
    int n;
    n = 0;
    while (tx1_oe !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    check(tx1_oe, 1'b1);
    rstn_i = 1'b0;
    #5 check({sclk_oe, tx1_oe, tx2_oe}, 8'h00);
  endtask
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    ext = 1'b1;
    go = 1'b0;
    cut = 1'b0;
    dseen = 1'b0;
    rw1 = 8'h00;
    rw2 = 8'h00;
    smp1 = 8'h00;
    smp2 = 8'h00;
    @(negedge clk_i);
    reset_dut(1'b1);
    xfer(8'h1E, 8'hC4);
    xfer(8'h81, 8'h6B);
    short_frame();
    reset_dut(1'b0);
    xfer(8'h1E, 8'hC4);
    xfer(8'h81, 8'h6B);
    reset_mid();
    complete_run();
  end
endmodule
